//--- rtl/dump_query_params.svh
`ifndef DUMP_QUERY_PARAMS_SVH
`define DUMP_QUERY_PARAMS_SVH

// ==========================================================================
// Register map (byte addresses on the register bus).
// ==========================================================================
`define ADDR_BUS_CFG     4'h0
`define ADDR_FUNC_CFG    4'h4
`define ADDR_STATUS      4'h8
`define ADDR_DUMP_COUNT  4'hC
`define BUS_CFG_RESET    32'h0000_000A
`define SEP_LSB          0
`define SVC_MASK_LSB     8
`define END_ID_BIT       16
`define TRIG_BIT         17
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

// ==========================================================================
// Output mode codes and command codes from the command parser.
// ==========================================================================
`define OUT_MODE_DEFAULT 3'h0
`define OUT_MODE_DUMP    3'h4
`define CMD_OTHER        3'h0
`define CMD_OUT_MODE     3'h1
`define CMD_FUNC_Q       3'h2
`define CMD_MCTL_Q       3'h3
`define CMD_IN1_Q        3'h4
`define CMD_IN2_Q        3'h5
`define CMD_BUS_Q        3'h6

// ==========================================================================
// Dump frame layout and characters.
// ==========================================================================
`define DUMP_CHARS       4'hE
`define DUMP_LAST_IDX    4'hD
`define HALF_DIGITS      6
`define MEAS_RATE_MIN    100
`define CLK_HZ           50000000

`endif

//--- rtl/dump_query_pkg.sv
package dump_query_pkg;
	typedef enum logic [3:0] {
		FN_FREQ_A, FN_FREQ_C, FN_PER, FN_TIME, FN_TOTG, FN_TOTS,
		FN_TOT_BUS, FN_RATIO, FN_VMAX, FN_VMIN
	} meas_func_t;
	typedef enum logic [2:0] {
		SC_ONE, SC_SIXTY, SC_256, SC_TENTH, SC_TEN
	} scale_t;
	typedef enum {TX_IDLE, TX_DUMP, TX_LINE, TX_SEP} tx_state_t;
endpackage

//--- rtl/fast_dump_query.sv
// The implementer's own choices: the address map and the AXI4-Lite register port.
`include "dump_query_params.svh"
// Operation
// RULE1 - Dump mode sends raw registers, no calculation
// RULE2 - No dump for voltage or bus-gated totalize
// RULE3 - Untriggered dump starts on output mode 4
// RULE4 - Triggered dump waits for group execute trigger
// RULE5 - Controller waits 70 ms before trigger
// RULE6 - Programming command stops dump at boundary
// RULE7 - Local request never stops dump
// RULE8 - Frame is two letters, twelve hex digits
// RULE9 - Digits form wide register, halves in order
// RULE10 - First letter picks formula from function
// RULE11 - Second letter encodes scale factor
// RULE12 - No end-or-identify with separator in dump
// RULE13 - Query answers use programming command syntax
// RULE14 - Two or three lines, each with separator; the code answers CMD_FUNC_Q with one line
// RULE15 - Measuring held until response done
// RULE16 - Controller puts query last in message
// RULE17 - New message abandons unread response lines
// RULE18 - Local adopts displayed settings only
// RULE19 - Remote keeps settings made in local
// RULE20 - Bus settings survive local and back
// RULE21 - Output mode codes 0 to 4
// RULE22 - Output mode resets to 0 via local
// RULE23 - Hex digits upper case, leading zeros kept
module fast_dump_query
	import dump_query_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [3:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	input  wire logic        msgStart,
	input  wire logic        cmdValid,
	input  wire logic [2:0]  cmdCode,
	input  wire logic [2:0]  cmdArg,
	input  wire logic        groupTrigger,
	input  wire logic        measBoundary,
	input  wire logic        measDone,
	input  wire logic [47:0] measRaw,
	input  wire logic [2:0]  measScale,
	input  wire logic        goLocal,
	input  wire logic        goRemote,
	input  wire logic [3:0]  panelFunc,
	input  wire logic        panelTrig,
	input  wire logic        fmtValid,
	input  wire logic [7:0]  fmtByte,
	input  wire logic        fmtLast,
	output logic             fmtReady,
	output logic             lineReq,
	output logic [2:0]       lineKind,
	output logic [1:0]       lineIdx,
	output logic [7:0]       txByte,
	output logic             txValid,
	output logic             txEoi,
	input  wire logic        txReady,
	output logic             measHold,
	output logic             oscComp,
	output logic             dumpActive,
	output logic             cmdError
);

	// ======================================================================
	// Helpers.
	// ======================================================================
	function automatic logic [7:0] hexChar(input logic [3:0] n);
		hexChar = (n < 4'hA) ? (8'h30 + {4'h0, n})
		                     : (8'h37 + {4'h0, n}); // RULE23
	endfunction

	function automatic logic [7:0] formulaChar(input meas_func_t f);
		case (f) // RULE10
			FN_FREQ_A: formulaChar = 8'h43;
			FN_FREQ_C: formulaChar = 8'h49;
			FN_PER:    formulaChar = 8'h4A;
			FN_TIME:   formulaChar = 8'h4B;
			FN_RATIO:  formulaChar = 8'h47;
			default:   formulaChar = 8'h46;
		endcase
	endfunction

	function automatic logic [7:0] scaleChar(input logic [2:0] s);
		case (s) // RULE11
			SC_SIXTY: scaleChar = 8'h48;
			SC_256:   scaleChar = 8'h4C;
			SC_TENTH: scaleChar = 8'h4E;
			SC_TEN:   scaleChar = 8'h4F;
			default:  scaleChar = 8'h50;
		endcase
	endfunction

	function automatic logic [1:0] linesOf(input logic [2:0] k);
		case (k) // RULE14
			`CMD_MCTL_Q, `CMD_BUS_Q:   linesOf = 2'd2;
			`CMD_IN1_Q, `CMD_IN2_Q:    linesOf = 2'd3;
			default:                   linesOf = 2'd1;
		endcase
	endfunction

	// ======================================================================
	// Settings state.
	// ======================================================================
	logic [31:0] busCfg_r;
	meas_func_t  func_r;
	logic [2:0]  outMode_r;
	logic        local_r;
	logic        dumpArmed_r;
	logic        dumpRun_r;
	logic        stopPend_r;
	logic [31:0] dumpCount_r;
	tx_state_t   txState_r;
	logic [3:0]  charIdx_r;
	logic [47:0] frame_r;
	logic [7:0]  letterF_r;
	logic [7:0]  letterM_r;
	logic [1:0]  linesLeft_r;
	logic        respBusy_r;
	logic        isQuery;
	logic        wrFire;
	logic        trigMode;
	logic        dumpBlocked;

	assign trigMode = busCfg_r[`TRIG_BIT];
	assign isQuery  = cmdValid && (cmdCode >= `CMD_FUNC_Q);
	assign dumpBlocked = (func_r == FN_VMAX) || (func_r == FN_VMIN)
	                     || (func_r == FN_TOT_BUS);

	// Bus-related settings are only ever touched by software.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			busCfg_r <= `BUS_CFG_RESET;
		end else if (wrFire && s_axi_awaddr == `ADDR_BUS_CFG) begin
			for (int b = 0; b < 4; b++) begin
				if (s_axi_wstrb[b]) begin
					busCfg_r[b*8 +: 8] <= s_axi_wdata[b*8 +: 8]; // RULE20
				end
			end
		end
	end

	// The displayed function wins on entry to local; on return to remote
	// nothing is restored, so the local choice simply stays.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			func_r  <= FN_FREQ_A;
			local_r <= 1'b0;
		end else if (goLocal && !dumpRun_r) begin // RULE7
			func_r  <= meas_func_t'(panelFunc); // RULE18
			local_r <= 1'b1;
		end else if (goRemote) begin
			local_r <= 1'b0; // RULE19
		end else if (wrFire && s_axi_awaddr == `ADDR_FUNC_CFG && !local_r
		             && s_axi_wstrb[0]) begin
			func_r <= meas_func_t'(s_axi_wdata[3:0]);
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			outMode_r <= `OUT_MODE_DEFAULT;
			cmdError  <= 1'b0;
		end else begin
			cmdError <= 1'b0;
			if (goRemote && local_r) begin
				outMode_r <= `OUT_MODE_DEFAULT; // RULE22
			end else if (cmdValid && cmdCode == `CMD_OUT_MODE) begin
				if (cmdArg > `OUT_MODE_DUMP
				    || (cmdArg == `OUT_MODE_DUMP && dumpBlocked)) begin
					cmdError <= 1'b1; // RULE2 RULE21
				end else begin
					outMode_r <= cmdArg; // RULE21
				end
			end
		end
	end

	// ======================================================================
	// Dump run control.
	// ======================================================================
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dumpArmed_r <= 1'b0;
			dumpRun_r   <= 1'b0;
			stopPend_r  <= 1'b0;
		end else begin
			if (cmdValid && cmdCode == `CMD_OUT_MODE
			    && cmdArg == `OUT_MODE_DUMP && !dumpBlocked) begin
				dumpArmed_r <= trigMode; // RULE4
				dumpRun_r   <= !trigMode; // RULE3
				stopPend_r  <= 1'b0;
			end else if (cmdValid && (dumpRun_r || dumpArmed_r)) begin
				stopPend_r <= 1'b1; // RULE6
			end else if (dumpArmed_r && groupTrigger) begin
				dumpArmed_r <= 1'b0;
				dumpRun_r   <= 1'b1; // RULE4
			end else if (stopPend_r && (measBoundary || dumpArmed_r)) begin
				dumpRun_r   <= 1'b0; // RULE6
				dumpArmed_r <= 1'b0;
				stopPend_r  <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dumpActive <= 1'b0;
			oscComp    <= 1'b1;
		end else begin
			dumpActive <= dumpRun_r || dumpArmed_r;
			oscComp    <= !outMode_r[1] && !outMode_r[2]; // RULE2
		end
	end

	// ======================================================================
	// Transmit sequencer: dump frames and query lines share one byte port.
	// ======================================================================
	logic txBusy;
	assign txBusy = txValid && !txReady;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			txState_r   <= TX_IDLE;
			charIdx_r   <= 4'h0;
			frame_r     <= 48'h0000_0000_0000;
			letterF_r   <= 8'h00;
			letterM_r   <= 8'h00;
			linesLeft_r <= 2'd0;
			respBusy_r  <= 1'b0;
			txValid     <= 1'b0;
			txByte      <= 8'h00;
			txEoi       <= 1'b0;
			lineReq     <= 1'b0;
			lineKind    <= 3'h0;
			lineIdx     <= 2'd0;
			fmtReady    <= 1'b0;
			dumpCount_r <= 32'h0000_0000;
		end else begin
			lineReq <= 1'b0;
			if (txValid && txReady) begin
				txValid <= 1'b0;
				txEoi   <= 1'b0;
			end
			if (msgStart) begin
				// Unread lines are dropped at once; a byte already on the
				// port is withdrawn too, except while a dump frame is in flight, since the controller moved on.
				respBusy_r  <= 1'b0; // RULE17
				linesLeft_r <= 2'd0;
				fmtReady    <= 1'b0;
				if (txState_r != TX_DUMP) begin
					txState_r <= TX_IDLE;
					txValid   <= 1'b0;
					txEoi     <= 1'b0;
				end
			end else begin
				case (txState_r)
					TX_IDLE: begin
						if (isQuery) begin
							respBusy_r  <= 1'b1; // RULE15
							lineKind    <= cmdCode;
							lineIdx     <= 2'd0;
							linesLeft_r <= linesOf(cmdCode); // RULE14
							lineReq     <= 1'b1;
							fmtReady    <= 1'b1;
							txState_r   <= TX_LINE;
						end else if (dumpRun_r && measDone) begin
							frame_r   <= measRaw; // RULE1
							letterF_r <= formulaChar(func_r);
							letterM_r <= scaleChar(measScale);
							charIdx_r <= 4'h0;
							txState_r <= TX_DUMP;
						end
					end
					TX_DUMP: begin
						if (!txBusy) begin
							txValid <= 1'b1;
							txEoi   <= 1'b0; // RULE12
							if (charIdx_r == `DUMP_CHARS) begin
								txByte    <= busCfg_r[`SEP_LSB +: 8];
								txState_r <= TX_IDLE;
								dumpCount_r <= dumpCount_r + 32'h0000_0001;
							end else if (charIdx_r == 4'h0) begin
								txByte <= letterF_r; // RULE8
							end else if (charIdx_r == 4'h1) begin
								txByte <= letterM_r; // RULE8
							end else begin
								txByte  <= hexChar(frame_r[47:44]); // RULE9
								frame_r <= {frame_r[43:0], 4'h0};
							end
							charIdx_r <= charIdx_r + 4'h1;
						end
					end
					TX_LINE: begin
						// Line text comes from the formatter in the same
						// syntax that programming accepts.
						if (fmtReady && fmtValid && !txBusy) begin
							txValid <= 1'b1;
							txByte  <= fmtByte; // RULE13
							txEoi   <= 1'b0;
							if (fmtLast) begin
								fmtReady  <= 1'b0;
								txState_r <= TX_SEP;
							end
						end
					end
					TX_SEP: begin
						if (!txBusy) begin
							txValid     <= 1'b1;
							txByte      <= busCfg_r[`SEP_LSB +: 8]; // RULE14
							txEoi       <= busCfg_r[`END_ID_BIT]
							               && linesLeft_r == 2'd1;
							linesLeft_r <= linesLeft_r - 2'd1;
							if (linesLeft_r == 2'd1) begin
								respBusy_r <= 1'b0;
								txState_r  <= TX_IDLE;
							end else begin
								lineIdx   <= lineIdx + 2'd1;
								lineReq   <= 1'b1;
								fmtReady  <= 1'b1;
								txState_r <= TX_LINE;
							end
						end
					end
					default: txState_r <= TX_IDLE;
				endcase
			end
		end
	end

	// Measuring is held from the cycle after the query until the response is done;
	// a dump frame in flight does not hold it, frame_r keeps the raw result.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			measHold <= 1'b0;
		end else begin
			measHold <= respBusy_r || isQuery; // RULE15
		end
	end

	// ======================================================================
	// Register bus slave.
	// ======================================================================
	assign wrFire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
	                && !s_axi_awready;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			s_axi_awready <= wrFire;
			s_axi_wready  <= wrFire;
			if (wrFire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (s_axi_awaddr == `ADDR_BUS_CFG
				                 || s_axi_awaddr == `ADDR_FUNC_CFG)
				                ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end else if (s_axi_arvalid && !s_axi_rvalid
			             && !s_axi_arready) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `RESP_OKAY;
				case (s_axi_araddr)
					`ADDR_BUS_CFG:    s_axi_rdata <= busCfg_r;
					`ADDR_FUNC_CFG:   s_axi_rdata <= {28'h000_0000, func_r};
					`ADDR_STATUS:     s_axi_rdata <= {24'h00_0000,
					                  respBusy_r, local_r, stopPend_r,
					                  dumpArmed_r, dumpRun_r, outMode_r};
					`ADDR_DUMP_COUNT: s_axi_rdata <= dumpCount_r;
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// ======================================================================
	// Checks.
	// ======================================================================
	property p_untrig_start;
		@(posedge clk_sys) disable iff (rst)
		(cmdValid && cmdCode == `CMD_OUT_MODE && cmdArg == `OUT_MODE_DUMP
		 && !dumpBlocked && !trigMode) |=> dumpRun_r;
	endproperty
	a_untrig_start: assert property (p_untrig_start) // RULE3
		else $error("dump did not start at once");

	property p_trig_wait;
		@(posedge clk_sys) disable iff (rst)
		(dumpArmed_r && !groupTrigger) |=> !dumpRun_r || $past(dumpRun_r);
	endproperty
	a_trig_wait: assert property (p_trig_wait) // RULE4
		else $error("dump ran before trigger");

	property p_blocked;
		@(posedge clk_sys) disable iff (rst)
		(cmdValid && cmdCode == `CMD_OUT_MODE && cmdArg == `OUT_MODE_DUMP
		 && dumpBlocked) |=> cmdError && outMode_r == $past(outMode_r);
	endproperty
	a_blocked: assert property (p_blocked) // RULE2
		else $error("dump accepted for blocked function");

	property p_stop_boundary;
		@(posedge clk_sys) disable iff (rst)
		($fell(dumpRun_r) && !$past(goRemote)) |-> $past(measBoundary);
	endproperty
	a_stop_boundary: assert property (p_stop_boundary) // RULE6
		else $error("dump stopped off a boundary");

	property p_local_keeps;
		@(posedge clk_sys) disable iff (rst)
		(goLocal && dumpRun_r && !stopPend_r) |=> dumpRun_r;
	endproperty
	a_local_keeps: assert property (p_local_keeps) // RULE7
		else $error("local request stopped dump");

	property p_no_eoi_dump;
		@(posedge clk_sys) disable iff (rst)
		(txState_r == TX_DUMP) |=> !txEoi;
	endproperty
	a_no_eoi_dump: assert property (p_no_eoi_dump) // RULE12
		else $error("end-or-identify during dump");

	property p_hold;
		@(posedge clk_sys) disable iff (rst)
		isQuery |=> ##1 measHold;
	endproperty
	a_hold: assert property (p_hold) // RULE15
		else $error("measuring not held after query");

	property p_abandon;
		@(posedge clk_sys) disable iff (rst)
		msgStart |=> !respBusy_r && !fmtReady;
	endproperty
	a_abandon: assert property (p_abandon) // RULE17
		else $error("response not abandoned");

	property p_mode_reset;
		@(posedge clk_sys) disable iff (rst)
		(goRemote && local_r) |=> outMode_r == `OUT_MODE_DEFAULT;
	endproperty
	a_mode_reset: assert property (p_mode_reset) // RULE22
		else $error("output mode not reset");

	property p_first_letter;
		@(posedge clk_sys) disable iff (rst)
		(txState_r == TX_DUMP && charIdx_r == 4'h0 && !txBusy)
		|=> txByte == letterF_r && txValid;
	endproperty
	a_first_letter: assert property (p_first_letter) // RULE8
		else $error("frame does not open with formula letter");

endmodule

//--- bench/ctrl_model.sv
// ==========================================================================
// Bus controller that listens to the byte stream and may stall it.
// ==========================================================================
module ctrl_model (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [7:0] txByte,
	input  wire logic       txValid,
	input  wire logic       txEoi,
	input  wire logic       slow,
	output logic            txReady
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [8:0] rxQ[$];

	// Stalling every other cycle proves that each byte is held until taken.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			txReady <= 1'b0;
		else
			txReady <= slow ? ~txReady : 1'b1;
	end

	always @(posedge clk_sys) begin
		if (txValid && txReady)
			rxQ.push_back({txEoi, txByte});
	end
endmodule

//--- bench/fast_dump_query_tb_top.sv
`include "dump_query_params.svh"
module fast_dump_query_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [5:0] MSG = 6'h20, GET = 6'h10, BND = 6'h08;
	localparam logic [5:0] DONE = 6'h04, LOCAL = 6'h02, REMOTE = 6'h01;

	logic        clk_sys, rst, slow, cmdValid, cmdError;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, fmtValid, fmtLast, fmtReady;
	logic        msgStart, groupTrigger, measBoundary, measDone, lineReq;
	logic        goLocal, goRemote, txValid, txEoi, txReady;
	logic        measHold, oscComp, dumpActive;
	logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr, panelFunc;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp, lineIdx;
	logic [2:0]  cmdCode, cmdArg, measScale, lineKind;
	logic [47:0] measRaw;
	logic [7:0]  fmtByte, txByte;
	logic [5:0]  pulses;
	int          error_cnt = 0, checked = 0, refuseCnt = 0;

	assign {msgStart, groupTrigger, measBoundary} = pulses[5:3];
	assign {measDone, goLocal, goRemote} = pulses[2:0];

	fast_dump_query fast_dump_query_inst (.panelTrig(1'b0), .*);
	ctrl_model ctrl_model_inst (.*);

	// The bench stands in for the line text source: two bytes a line.
	always @(posedge clk_sys) begin
		if (cmdError)
			refuseCnt <= refuseCnt + 1;
		if (msgStart)
			fmtValid <= 1'b0;
		else if (lineReq) begin
			fmtValid <= 1'b1;
			fmtByte  <= 8'(8'h41 + lineIdx);
			fmtLast  <= 1'b0;
		end else if (fmtValid && fmtReady && !(txValid && !txReady)) begin
			fmtByte <= 8'h5A;
			fmtLast <= 1'b1;
			if (fmtLast)
				fmtValid <= 1'b0;
		end
	end

	// ======================================================================
	// Checking and closing.
	// ======================================================================
	task automatic tally_and_finish;
		if (error_cnt == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic fail(input string m);
		error_cnt++;
		$display("CHECK FAILED at %0t ns: %s", $time, m);
	endtask

	task automatic to_out;
		fail("wait ran out");
		tally_and_finish();
	endtask

	task automatic chk_val(input logic [47:0] g, x, input string m);
		checked++;
		if (g !== x)
			fail(m);
	endtask

	task automatic chk_flag(input logic g, x, input string m);
		checked++;
		if (g !== x)
			fail(m);
	endtask

	task automatic chk_frame(input logic [7:0] e[$], input logic eoiEnd);
		int k;
		for (k = 0; k < 600 && ctrl_model_inst.rxQ.size() < e.size(); k++)
			@(posedge clk_sys);
		if (k == 600)
			to_out();
		foreach (e[i]) begin
			chk_val(ctrl_model_inst.rxQ[i][7:0], e[i], "byte");
			chk_flag(ctrl_model_inst.rxQ[i][8], eoiEnd && i == e.size() - 1,
				"eoi");
		end
		ctrl_model_inst.rxQ.delete();
	endtask

	function automatic logic [7:0] hx(input logic [3:0] v);
		return (v < 4'hA) ? 8'h30 + v : 8'h37 + v;
	endfunction

	// ======================================================================
	// Bus and stimulus tasks.
	// ======================================================================
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] resp);
		int n;
		logic aw, w, b;
		@(posedge clk_sys);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk_sys);
			aw = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge clk_sys);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
			if (b)
				break;
		end
		s_axi_bready <= 1'b0;
		if (n == 50)
			to_out();
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] resp);
		int n;
		logic ar, r;
		@(posedge clk_sys);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk_sys);
			ar = s_axi_arready;
			r = s_axi_rvalid;
			d = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge clk_sys);
			if (ar)
				s_axi_arvalid <= 1'b0;
			if (r)
				break;
		end
		s_axi_rready <= 1'b0;
		if (n == 50)
			to_out();
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk_val(r, er, "bresp");
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, e);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk_val(r, `RESP_OKAY, "rresp");
		chk_val(d & m, e, "rdata");
	endtask

	task automatic send_cmd(input logic [2:0] c, a);
		@(posedge clk_sys);
		cmdValid <= 1'b1;
		cmdCode  <= c;
		cmdArg   <= a;
		@(posedge clk_sys);
		cmdValid <= 1'b0;
	endtask

	task automatic strobe(input logic [5:0] m);
		@(posedge clk_sys);
		pulses <= m;
		@(posedge clk_sys);
		pulses <= '0;
	endtask

	task automatic settle;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	task automatic stop_dump;
		send_cmd(`CMD_OTHER, 3'h0);
		settle();
		chk_flag(dumpActive, 1'b1, "stopped early");
		strobe(BND);
		settle();
		chk_flag(dumpActive, 1'b0, "not stopped");
	endtask

	// ======================================================================
	// Scenarios.
	// ======================================================================
	task automatic sc_reset;
		@(negedge clk_sys);
		chk_flag(oscComp, 1'b1, "osc at reset");
		rd_chk(`ADDR_BUS_CFG, 32'hFFFF_FFFF, `BUS_CFG_RESET);
		rd_chk(`ADDR_STATUS, 32'h7, 32'h0);
		wr(`ADDR_STATUS, 32'h0, `RESP_SLVERR);
	endtask

	task automatic sc_modes;
		logic [1:0] r;
		for (int c = 0; c < 4; c++) begin
			send_cmd(`CMD_OUT_MODE, 3'(c));
			settle();
			chk_flag(oscComp, c < 2, "osc mode");
			rd_chk(`ADDR_STATUS, 32'h7, 32'(c));
		end
		wr(`ADDR_BUS_CFG, 32'h0001_3F0D, `RESP_OKAY);
		wr(`ADDR_FUNC_CFG, 32'h2, `RESP_OKAY);
		panelFunc <= 4'h7;
		strobe(LOCAL);
		rd_chk(`ADDR_STATUS, 32'h40, 32'h40);
		axi_wr(`ADDR_FUNC_CFG, 32'h3, r);
		rd_chk(`ADDR_FUNC_CFG, 32'hF, 32'h7);
		strobe(REMOTE);
		rd_chk(`ADDR_FUNC_CFG, 32'hF, 32'h7);
		rd_chk(`ADDR_BUS_CFG, 32'h3_FFFF, 32'h1_3F0D);
		rd_chk(`ADDR_STATUS, 32'h47, 32'h0);
		chk_flag(oscComp, 1'b1, "osc back");
		wr(`ADDR_BUS_CFG, 32'h0001_000A, `RESP_OKAY);
	endtask

	task automatic sc_dump;
		logic [3:0] fn[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
		string fl = "CIJKFG";
		string sl = "PHLNO";
		logic [7:0] e[$];
		logic [47:0] raw;
		for (int i = 0; i < 6; i++) begin
			raw = i ? 48'h9855_5B00_0257 + i : 48'h683;
			e = '{fl[i], sl[i % 5]};
			for (int d = 11; d >= 0; d--)
				e.push_back(hx(raw[d*4 +: 4]));
			e.push_back(8'h0A);
			wr(`ADDR_FUNC_CFG, {28'h0, fn[i]}, `RESP_OKAY);
			send_cmd(`CMD_OUT_MODE, 3'h4);
			slow <= i[0];
			measScale <= 3'(i % 5);
			measRaw <= raw;
			settle();
			chk_flag(dumpActive, 1'b1, "no start");
			chk_flag(oscComp, 1'b0, "osc in dump");
			strobe(DONE);
			chk_frame(e, 1'b0);
			stop_dump();
		end
		rd_chk(`ADDR_DUMP_COUNT, 32'hFFFF_FFFF, 32'h6);
	endtask

	task automatic sc_refuse;
		int c;
		logic [3:0] bad[3] = '{4'h6, 4'h8, 4'h9};
		foreach (bad[i]) begin
			wr(`ADDR_FUNC_CFG, {28'h0, bad[i]}, `RESP_OKAY);
			c = refuseCnt;
			send_cmd(`CMD_OUT_MODE, 3'h4);
			settle();
			chk_val(refuseCnt - c, 1, "not refused");
			chk_flag(dumpActive, 1'b0, "dump on");
		end
		wr(`ADDR_FUNC_CFG, 32'h2, `RESP_OKAY);
		c = refuseCnt;
		send_cmd(`CMD_OUT_MODE, 3'h5);
		settle();
		chk_val(refuseCnt - c, 1, "code 5 taken");
		rd_chk(`ADDR_STATUS, 32'h7, 32'h4);
	endtask

	task automatic sc_trig;
		logic [7:0] e[$] = '{8'h4A, 8'h50};
		for (int d = 0; d < 9; d++)
			e.push_back(8'h30);
		e = {e, 8'h36, 8'h38, 8'h33, 8'h0A};
		wr(`ADDR_BUS_CFG, 32'h0003_000A, `RESP_OKAY);
		wr(`ADDR_FUNC_CFG, 32'h2, `RESP_OKAY);
		send_cmd(`CMD_OUT_MODE, 3'h4);
		rd_chk(`ADDR_STATUS, 32'h18, 32'h10);
		measScale <= 3'h0;
		measRaw <= 48'h683;
		strobe(DONE);
		settle();
		chk_val(ctrl_model_inst.rxQ.size(), 0, "sent early");
		// The real gap would make the run far too long; nothing here counts it.
		repeat (50) @(posedge clk_sys);
		strobe(GET);
		strobe(DONE);
		chk_frame(e, 1'b0);
		strobe(LOCAL);
		settle();
		chk_flag(dumpActive, 1'b1, "local stop");
		rd_chk(`ADDR_STATUS, 32'h40, 32'h0);
		stop_dump();
	endtask

	task automatic sc_query;
		int lines[5] = '{1, 2, 3, 3, 2};
		logic [7:0] e[$];
		wr(`ADDR_BUS_CFG, 32'h0001_000D, `RESP_OKAY);
		foreach (lines[q]) begin
			e.delete();
			for (int l = 0; l < lines[q]; l++)
				e = {e, 8'(8'h41 + l), 8'h5A, 8'h0D};
			send_cmd(3'(q + 2), 3'h0);
			settle();
			chk_flag(measHold, 1'b1, "no hold");
			chk_val(lineKind, q + 2, "line kind");
			chk_frame(e, 1'b1);
			settle();
			chk_flag(measHold, 1'b0, "hold kept");
		end
		send_cmd(`CMD_IN1_Q, 3'h0);
		chk_frame('{8'h41, 8'h5A, 8'h0D}, 1'b0);
		strobe(MSG);
		settle();
		chk_flag(measHold, 1'b0, "not abandoned");
		// Bytes taken before the new message landed are legal.
		ctrl_model_inst.rxQ.delete();
		repeat (20) @(posedge clk_sys);
		chk_val(ctrl_model_inst.rxQ.size(), 0, "lines left");
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, cmdValid, fmtValid, fmtLast, slow} = '0;
		{s_axi_awaddr, s_axi_araddr, panelFunc, cmdCode, cmdArg} = '0;
		{s_axi_wdata, measRaw, fmtByte, measScale, pulses} = '0;
		s_axi_wstrb = 4'hF;
		rst = 1'b1;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		sc_reset();
		sc_modes();
		sc_dump();
		sc_refuse();
		sc_trig();
		sc_query();
		tally_and_finish();
	end
endmodule
